// *** inc/ssae_pkg.sv ***
// Constants, types and state record of the bit-serial shift/arithmetic datapath
// Summary of operation
// - Left shift: extension MSB caught at word end, then delays accumulator left
// - Left cycle: accumulator MSB caught at word end, moved at T24 to gating
// - Without cycle modifier, zeros enter extension low end
// - Count decrements at phase 3 T24; zero sets shift-done, forcing phase 7
// - Phase 7 bumps program counter, ends instruction, loads opcode 20 at T24
// - Left shift sets overflow at T0 when sign would change
// - Left cycle never sets overflow
// - Normalize sets shift-done early once two top bits differ
// - Normalize decrements index serially, carry flop as borrow
// - Add 55, subtract 54: phase 0 then phase 6 serial add
// - Subtract inverts operand and presets carry
// - Phase 6 word end returns to phase 0
// - Phase 6 T0 sets overflow when inputs agree but sum differs
// - Multiply step phase 0: extend sign two places, shift pair right
// - Multiply step phase 6: add or subtract multiplicand, shift right again
// - Multiplier bits examined in phase 0
// - Multiplier bit B21 held in subtract flag
// - Phase 0 T23: match flag when two lowest multiplier bits equal
// - Match starts arithmetic one clock later, doubling multiplicand
// - Three equal bits set gating flop at phase 6 T24, adding zero
// - Right-shift flag set at phase 0 T24, cleared at instruction end
// - Overflow set makes right shift extend zeros; low bit enters extension top
// - Count and modifiers move into the address register, modifiers on top
package ssae_pkg;
  // Bit slots of one word time: T24, T23..T0, then end-of-word
  localparam logic [4:0] SLOT_T24 = 5'h00;
  localparam logic [4:0] SLOT_T23 = 5'h01;
  localparam logic [4:0] SLOT_T9 = 5'h0F;
  localparam logic [4:0] SLOT_T0 = 5'h18;
  localparam logic [4:0] SLOT_TP = 5'h19;
  localparam logic [5:0] OP_NOP = 6'h10;
  localparam logic [5:0] OP_SUB = 6'h2C;
  localparam logic [5:0] OP_ADD = 6'h2D;
  localparam logic [5:0] OP_MUS = 6'h34;
  localparam logic [5:0] OP_SHL = 6'h37;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ACC = 8'h04;
  localparam logic [7:0] OFF_EXT = 8'h08;
  localparam logic [7:0] OFF_IDX = 8'h0C;
  localparam logic [7:0] OFF_OPND = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;
  localparam logic [7:0] OFF_PC = 8'h18;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_OP_LSB = 8;
  localparam int CTRL_CNT_LSB = 16;
  localparam int CTRL_CYC_BIT = 22;
  localparam int CTRL_NORM_BIT = 23;
  localparam int STAT_OF_BIT = 4;
  localparam int ADDR_CYC_BIT = 13;
  localparam int ADDR_NORM_BIT = 12;

  typedef enum logic [2:0] {PH_0, PH_1, PH_3, PH_6, PH_7} ssae_phase_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } ssae_apb_req_t;

  typedef struct packed {
    logic run;
    logic pend;
    ssae_phase_t phase;
    logic [4:0] slot;
    logic [5:0] opcode;
    logic [5:0] cmd_count;
    logic cmd_cyc;
    logic cmd_norm;
    logic [13:0] addr;
    logic [13:0] pc;
    logic [23:0] a;
    logic [23:0] b;
    logic [23:0] x;
    logic [23:0] c;
    logic [25:0] ax;
    logic overflow_flag;
    logic shift_done_flag;
    logic right_shift_flag;
    logic subtract_flag;
    logic delay_match_flop;
    logic increment_flop;
    logic gating_delay_flop;
    logic index_carry_flop;
    logic adder_carry_flop;
    logic end_pulse;
    logic [31:0] rdata;
  } ssae_state_t;

  localparam ssae_state_t SSAE_STATE_RST = '0;
endpackage

// *** logic/ssae_exec.sv ***
// Bit-serial shift, add/subtract and multiply-step datapath with APB registers
`timescale 1ns/1ns
module ssae_exec
  import ssae_pkg::*;
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire ssae_apb_req_t apb_req_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic busy_o,
  output logic instr_end_o,
  output logic overflow_o,
  output logic word_end_o
);
  ssae_state_t s_r;
  ssae_state_t s_nxt;
  logic hit;
  logic setup;
  logic wr;
  logic busy;
  logic is_sub;
  logic is_addsub;
  logic is_mus;
  logic is_shl;
  logic cyc;
  logic norm;
  logic bit_slot;

  assign hit = (apb_req_i.paddr == OFF_CTRL) || (apb_req_i.paddr == OFF_ACC)
    || (apb_req_i.paddr == OFF_EXT) || (apb_req_i.paddr == OFF_IDX)
    || (apb_req_i.paddr == OFF_OPND) || (apb_req_i.paddr == OFF_STAT)
    || (apb_req_i.paddr == OFF_PC);
  assign setup = apb_req_i.psel && !apb_req_i.penable;
  assign wr = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite && hit;
  assign busy = s_r.run || s_r.pend;
  assign is_sub = s_r.opcode == OP_SUB;
  assign is_addsub = is_sub || (s_r.opcode == OP_ADD);
  assign is_mus = s_r.opcode == OP_MUS;
  assign is_shl = s_r.opcode == OP_SHL;
  assign cyc = s_r.addr[ADDR_CYC_BIT];
  assign norm = s_r.addr[ADDR_NORM_BIT];
  // Data bits occupy T23..T0, least significant first
  assign bit_slot = (s_r.slot >= SLOT_T23) && (s_r.slot <= SLOT_T0);

  always_comb
  begin
    logic xb;
    logic yb;
    logic sb;
    logic ext;
    logic [25:0] opnd;
    logic [25:0] sum26;
    xb = 1'b0;
    yb = 1'b0;
    sb = 1'b0;
    ext = 1'b0;
    opnd = '0;
    sum26 = '0;
    s_nxt = s_r;
    s_nxt.end_pulse = 1'b0;
    s_nxt.slot = (s_r.slot == SLOT_TP) ? SLOT_T24 : s_r.slot + 5'h01;

    // Read data is latched in the setup cycle so it comes from flops
    if (setup)
    begin
      if (apb_req_i.paddr == OFF_CTRL)
        s_nxt.rdata = {8'h00, s_r.cmd_norm, s_r.cmd_cyc, s_r.cmd_count, 2'b00,
          s_r.opcode, 8'h00};
      else if (apb_req_i.paddr == OFF_ACC)
        s_nxt.rdata = {8'h00, s_r.a};
      else if (apb_req_i.paddr == OFF_EXT)
        s_nxt.rdata = {8'h00, s_r.b};
      else if (apb_req_i.paddr == OFF_IDX)
        s_nxt.rdata = {8'h00, s_r.x};
      else if (apb_req_i.paddr == OFF_OPND)
        s_nxt.rdata = {8'h00, s_r.c};
      else if (apb_req_i.paddr == OFF_STAT)
        s_nxt.rdata = {22'h000000, s_r.gating_delay_flop, s_r.delay_match_flop,
          s_r.subtract_flag, s_r.right_shift_flag, s_r.shift_done_flag,
          s_r.overflow_flag, s_r.phase, busy};
      else if (apb_req_i.paddr == OFF_PC)
        s_nxt.rdata = {18'h00000, s_r.pc};
      else
        s_nxt.rdata = 32'h00000000;
    end

    // Software writes come first so that a hardware set in the same cycle wins
    if (wr)
    begin
      if (apb_req_i.paddr == OFF_STAT)
      begin
        if (apb_req_i.pwdata[STAT_OF_BIT])
          s_nxt.overflow_flag = 1'b0;
      end
      else if (!busy)
      begin
        if (apb_req_i.paddr == OFF_CTRL)
        begin
          s_nxt.opcode = apb_req_i.pwdata[CTRL_OP_LSB +: 6];
          s_nxt.cmd_count = apb_req_i.pwdata[CTRL_CNT_LSB +: 6];
          s_nxt.cmd_cyc = apb_req_i.pwdata[CTRL_CYC_BIT];
          s_nxt.cmd_norm = apb_req_i.pwdata[CTRL_NORM_BIT];
          s_nxt.pend = apb_req_i.pwdata[CTRL_START_BIT];
        end
        else if (apb_req_i.paddr == OFF_ACC)
          s_nxt.a = apb_req_i.pwdata[23:0];
        else if (apb_req_i.paddr == OFF_EXT)
          s_nxt.b = apb_req_i.pwdata[23:0];
        else if (apb_req_i.paddr == OFF_IDX)
          s_nxt.x = apb_req_i.pwdata[23:0];
        else if (apb_req_i.paddr == OFF_OPND)
          s_nxt.c = apb_req_i.pwdata[23:0];
        else if (apb_req_i.paddr == OFF_PC)
          s_nxt.pc = apb_req_i.pwdata[13:0];
      end
    end

    // A start waits for a word boundary so phase 0 sees a whole word
    if (s_r.pend && (s_r.slot == SLOT_TP))
    begin
      s_nxt.pend = 1'b0;
      s_nxt.run = 1'b1;
      s_nxt.phase = PH_0;
    end

    if (s_r.run)
    begin
      case (s_r.phase)
        PH_0:
        begin
          if (is_mus && (s_r.slot == SLOT_T24))
            s_nxt.right_shift_flag = 1'b1;
          // Multiplier bits are read here, phase 6 sees them too late
          if (is_mus && (s_r.slot == SLOT_T23))
          begin
            s_nxt.delay_match_flop = s_r.b[0] == s_r.b[1];
            s_nxt.subtract_flag = s_r.b[2];
          end
          if (is_shl && (s_r.slot == SLOT_T9))
          begin
            s_nxt.addr = '0;
            s_nxt.addr[ADDR_CYC_BIT] = s_r.cmd_cyc;
            s_nxt.addr[ADDR_NORM_BIT] = s_r.cmd_norm;
            s_nxt.addr[5:0] = s_r.cmd_count;
          end
          if (s_r.slot == SLOT_TP)
          begin
            if (is_mus)
            begin
              ext = s_r.overflow_flag ? 1'b0 : s_r.a[23];
              s_nxt.ax = {ext, ext, ext, s_r.a[23:1]};
              s_nxt.a = {ext, s_r.a[23:1]};
              s_nxt.b = {s_r.a[0], s_r.b[23:1]};
              s_nxt.overflow_flag = 1'b0;
              s_nxt.phase = PH_6;
            end
            else if (is_addsub)
              s_nxt.phase = PH_6;
            else if (is_shl)
            begin
              s_nxt.delay_match_flop = s_r.b[23];
              s_nxt.increment_flop = s_r.a[23];
              s_nxt.phase = PH_1;
            end
            else
              s_nxt.phase = PH_7;
          end
        end
        PH_1:
        begin
          // Memory is idle here; this word only checks the count and the top bits
          if (s_r.slot == SLOT_T0)
          begin
            if (s_r.addr[5:0] == 6'h00)
              s_nxt.shift_done_flag = 1'b1;
            if (norm && (s_r.a[23] != s_r.a[22]))
              s_nxt.shift_done_flag = 1'b1;
          end
          if (s_r.slot == SLOT_TP)
            s_nxt.phase = s_r.shift_done_flag ? PH_7 : PH_3;
        end
        PH_3:
        begin
          if (s_r.slot == SLOT_T24)
          begin
            s_nxt.addr[5:0] = s_r.addr[5:0] - 6'h01;
            s_nxt.gating_delay_flop = cyc && s_r.increment_flop;
            s_nxt.increment_flop = 1'b0;
            s_nxt.index_carry_flop = 1'b1;
          end
          if (norm && bit_slot)
          begin
            xb = s_r.x[0];
            s_nxt.x = {xb ^ s_r.index_carry_flop, s_r.x[23:1]};
            s_nxt.index_carry_flop = s_r.index_carry_flop && !xb;
          end
          if (s_r.slot == SLOT_T0)
          begin
            if (!cyc && (s_r.a[23] != s_r.a[22]))
              s_nxt.overflow_flag = 1'b1;
            if (s_r.addr[5:0] == 6'h00)
              s_nxt.shift_done_flag = 1'b1;
            // This shift still happens and leaves a normalized value; no further shift follows
            if (norm && (s_r.a[22] != s_r.a[21]))
              s_nxt.shift_done_flag = 1'b1;
          end
          if (s_r.slot == SLOT_TP)
          begin
            s_nxt.a = {s_r.a[22:0], s_r.delay_match_flop};
            s_nxt.b = {s_r.b[22:0], s_r.gating_delay_flop};
            s_nxt.delay_match_flop = s_r.b[22];
            s_nxt.increment_flop = s_r.a[22];
            if (s_r.shift_done_flag)
              s_nxt.phase = PH_7;
          end
        end
        PH_6:
        begin
          if (is_addsub)
          begin
            if (s_r.slot == SLOT_T24)
              s_nxt.adder_carry_flop = is_sub;
            if (bit_slot)
            begin
              xb = s_r.a[0];
              yb = s_r.c[0] ^ is_sub;
              sb = xb ^ yb ^ s_r.adder_carry_flop;
              s_nxt.adder_carry_flop = (xb && yb) || (xb && s_r.adder_carry_flop)
                || (yb && s_r.adder_carry_flop);
              s_nxt.a = {sb, s_r.a[23:1]};
              s_nxt.c = {s_r.c[0], s_r.c[23:1]};
              if ((s_r.slot == SLOT_T0) && (xb == yb) && (sb != xb))
                s_nxt.overflow_flag = 1'b1;
            end
          end
          else if (is_mus)
          begin
            // Original multiplier bits B22 now sit in the extension low bit
            if (s_r.slot == SLOT_T24)
              s_nxt.gating_delay_flop = s_r.delay_match_flop
                && (s_r.b[0] == s_r.subtract_flag);
            if (s_r.slot == SLOT_TP)
            begin
              // A one-clock later start is the doubled operand
              if (s_r.gating_delay_flop)
                opnd = '0;
              else if (s_r.delay_match_flop)
                opnd = {s_r.c[23], s_r.c, 1'b0};
              else
                opnd = {s_r.c[23], s_r.c[23], s_r.c};
              sum26 = s_r.subtract_flag ? s_r.ax - opnd : s_r.ax + opnd;
              s_nxt.ax = {sum26[25], sum26[25:1]};
              s_nxt.a = sum26[24:1];
              s_nxt.b = {sum26[0], s_r.b[23:1]};
            end
          end
        end
        PH_7:
        begin
          if (s_r.slot == SLOT_T24)
            s_nxt.opcode = OP_NOP;
        end
        default:
        begin
          s_nxt.phase = PH_0;
        end
      endcase

      if ((s_r.slot == SLOT_TP) && ((s_r.phase == PH_6) || (s_r.phase == PH_7)))
      begin
        s_nxt.run = 1'b0;
        s_nxt.phase = PH_0;
        s_nxt.pc = s_r.pc + 14'h0001;
        s_nxt.end_pulse = 1'b1;
        s_nxt.right_shift_flag = 1'b0;
        s_nxt.subtract_flag = 1'b0;
        s_nxt.delay_match_flop = 1'b0;
        s_nxt.gating_delay_flop = 1'b0;
        s_nxt.shift_done_flag = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
      s_r <= SSAE_STATE_RST;
    else
      s_r <= s_nxt;
  end

  // Zero-wait slave: every access phase completes at once
  assign pready_o = 1'b1;
  assign pslverr_o = apb_req_i.psel && apb_req_i.penable && !hit;
  assign prdata_o = s_r.rdata;
  assign busy_o = busy;
  assign instr_end_o = s_r.end_pulse;
  assign overflow_o = s_r.overflow_flag;
  assign word_end_o = s_r.slot == SLOT_TP;

  // Checks
  logic [22:0] a_lo;
  logic [5:0] cnt_seen;
  logic ph3;
  logic ph6;
  assign a_lo = s_r.a[22:0];
  assign cnt_seen = s_r.addr[5:0];
  assign ph3 = s_r.run && (s_r.phase == PH_3);
  assign ph6 = s_r.run && (s_r.phase == PH_6);

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);

  left_shift_a: assert property (ph3 && (s_r.slot == SLOT_TP) |=>
    (s_r.a == {$past(a_lo), $past(s_r.delay_match_flop)}))
    else $error("left shift did not use delay flop");
  zero_fill_a: assert property (ph3 && !cyc && (s_r.slot == SLOT_T24) |=>
    !s_r.gating_delay_flop ##25 !s_r.b[0])
    else $error("nonzero fill in left shift");
  count_down_a: assert property (ph3 && (s_r.slot == SLOT_T24) |=>
    cnt_seen == $past(cnt_seen) - 6'h01)
    else $error("shift count not decremented");
  done_phase7_a: assert property (ph3 && s_r.shift_done_flag
    && (s_r.slot == SLOT_TP) |=> s_r.phase == PH_7 ##1 s_r.opcode == OP_NOP)
    else $error("shift done did not force phase 7 and opcode 20");
  cycle_no_ovf_a: assert property (ph3 && cyc && !s_r.overflow_flag
    |=> !s_r.overflow_flag)
    else $error("overflow set in left cycle");
  shift_ovf_a: assert property (ph3 && !cyc && (s_r.slot == SLOT_T0)
    && (s_r.a[23] != s_r.a[22]) |=> s_r.overflow_flag)
    else $error("left shift sign change missed");
  sub_carry_a: assert property (ph6 && is_sub && (s_r.slot == SLOT_T24)
    |=> s_r.adder_carry_flop)
    else $error("carry not preset for subtract");
  phase_return_a: assert property (ph6 && (s_r.slot == SLOT_TP)
    |=> (s_r.phase == PH_0) && !s_r.run && s_r.end_pulse)
    else $error("phase 6 did not return to phase 0");
  match_flag_a: assert property (s_r.run && is_mus && (s_r.phase == PH_0)
    && (s_r.slot == SLOT_T23) |=> s_r.delay_match_flop == ($past(s_r.b[0]) == $past(s_r.b[1])))
    else $error("match flag wrong");
  rsf_span_a: assert property (s_r.run && is_mus && (s_r.phase == PH_0)
    && (s_r.slot == SLOT_T24) |=> s_r.right_shift_flag [*8] ##44 s_r.end_pulse && !s_r.right_shift_flag)
    else $error("right shift flag span wrong");
  index_borrow_a: assert property (ph3 && norm && (s_r.slot == SLOT_T24)
    |=> s_r.index_carry_flop)
    else $error("index borrow not preset");
  add_ovf_a: assert property (ph6 && is_addsub && (s_r.slot == SLOT_T0)
    && (s_r.a[0] == (s_r.c[0] ^ is_sub)) && (s_r.adder_carry_flop != s_r.a[0])
    |=> s_r.overflow_flag)
    else $error("add overflow missed");
  zero_add_a: assert property (ph6 && is_mus && (s_r.slot == SLOT_T24)
    && s_r.delay_match_flop && (s_r.b[0] == s_r.subtract_flag) |=> s_r.gating_delay_flop)
    else $error("gating flop not set for zero add");
  sub_pick_a: assert property (s_r.run && is_mus && (s_r.phase == PH_0)
    && (s_r.slot == SLOT_T23) |=> s_r.subtract_flag == $past(s_r.b[2]))
    else $error("subtract flag did not take multiplier bit");
  mus_ovf_clr_a: assert property (s_r.run && is_mus && (s_r.phase == PH_0)
    && (s_r.slot == SLOT_TP) |=> !s_r.overflow_flag)
    else $error("overflow not cleared after right shift");
  opcode_nop_a: assert property (s_r.run && (s_r.phase == PH_7)
    && (s_r.slot == SLOT_T24) |=> s_r.opcode == OP_NOP)
    else $error("opcode not reloaded in phase 7");
  norm_stop_a: assert property (ph3 && norm && (s_r.slot == SLOT_T0)
    && (s_r.a[22] != s_r.a[21]) |=> s_r.shift_done_flag)
    else $error("normalize did not stop early");

  shift_done_c: cover property (ph3 && (s_r.slot == SLOT_TP) && s_r.shift_done_flag);
  add_ovf_c: cover property (ph6 && is_addsub && $rose(s_r.overflow_flag));
  mus_zero_c: cover property (ph6 && is_mus && s_r.gating_delay_flop);
  norm_early_c: cover property (ph3 && norm && s_r.shift_done_flag && (cnt_seen != 6'h00));
  sub_ovf_c: cover property (ph6 && is_sub && $rose(s_r.overflow_flag));
endmodule

// *** tb/ssae_seq_model.sv ***
// Sequencer-side model that loads operands and starts instructions over APB
`timescale 1ns/1ns
module ssae_seq_model
  import ssae_pkg::*;
(
  input wire logic mclk_i,
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i,
  output ssae_apb_req_t req_o
);
  initial
  begin
    req_o = '0;
  end

  // Request held until pready is seen high at a rising edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge mclk_i);
    req_o.psel <= 1'b1;
    req_o.penable <= 1'b0;
    req_o.pwrite <= wr;
    req_o.paddr <= a;
    req_o.pwdata <= wd;
    @(posedge mclk_i);
    req_o.penable <= 1'b1;
    @(posedge mclk_i);
    while (pready_i !== 1'b1)
    begin
      @(posedge mclk_i);
    end
    rd = prdata_i;
    err = pslverr_i;
    req_o.psel <= 1'b0;
    req_o.penable <= 1'b0;
    // Released lines show inverted data so stale values cannot pass
    req_o.paddr <= ~a;
    req_o.pwdata <= ~wd;
  endtask
endmodule

// *** tb/test_serial_shift_arith_exec.sv ***
// Self-checking bench for the bit-serial shift and arithmetic datapath
`timescale 1ns/1ns
module test_serial_shift_arith_exec;
  import ssae_pkg::*;
  logic mclk;
  logic resetn;
  ssae_apb_req_t req;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic busy;
  logic iend;
  logic ovf;
  logic wend;
  int err_count;
  int n_checks;

  ssae_exec uut (.mclk_i(mclk), .resetn_i(resetn), .apb_req_i(req), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .busy_o(busy), .instr_end_o(iend),
    .overflow_o(ovf), .word_end_o(wend));
  ssae_seq_model seq (.mclk_i(mclk), .prdata_i(prdata), .pready_i(pready),
    .pslverr_i(pslverr), .req_o(req));

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    seq.xfer(1'b1, a, d, r, e);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    seq.xfer(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask

  // Start is deferred to a word boundary, so allow up to one word of slack
  task automatic run(input logic [5:0] op, input logic [5:0] cnt, input logic cyc,
                     input logic nrm, input int len, input logic poke);
    int c;
    wr(OFF_CTRL, {8'h00, nrm, cyc, cnt, 2'b00, op, 7'h00, 1'b1});
    if (poke)
      wr(OFF_ACC, 32'h00ABCD);
    c = 0;
    while (c < 3000 && iend !== 1'b1)
    begin
      @(negedge mclk);
      c++;
    end
    chk({31'h0, iend}, 32'h1);
    chk({31'h0, (c >= len - 4 && c <= len + 28)}, 32'h1);
  endtask

  task automatic multiply_step(input logic [31:0] a, b, c, ea, eb);
    wr(OFF_ACC, a);
    wr(OFF_EXT, b);
    wr(OFF_OPND, c);
    run(OP_MUS, 6'h00, 1'b0, 1'b0, 52, 1'b0);
    rdc(OFF_ACC, ea);
    rdc(OFF_EXT, eb);
  endtask

  task automatic t_reset;
    logic [31:0] r;
    logic e;
    rdc(OFF_STAT, 32'h0);
    chk({31'h0, busy}, 32'h0);
    seq.xfer(1'b0, 8'h1C, 32'h0, r, e);
    chk(r, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("test reset done");
  endtask

  task automatic t_add;
    wr(OFF_ACC, 32'h000005);
    wr(OFF_OPND, 32'h000003);
    run(OP_ADD, 6'h00, 1'b0, 1'b0, 52, 1'b1);
    rdc(OFF_ACC, 32'h000008);
    chk({31'h0, ovf}, 32'h0);
    wr(OFF_ACC, 32'h7FFFFF);
    wr(OFF_OPND, 32'h000001);
    run(OP_ADD, 6'h00, 1'b0, 1'b0, 52, 1'b0);
    rdc(OFF_ACC, 32'h800000);
    chk({31'h0, ovf}, 32'h1);
    wr(OFF_STAT, 32'h10);
    // The clear lands at the edge that ends the write, so look half a cycle later
    @(negedge mclk);
    chk({31'h0, ovf}, 32'h0);
    $display("test add done");
  endtask

  task automatic t_sub;
    wr(OFF_ACC, 32'h000003);
    wr(OFF_OPND, 32'h000005);
    run(OP_SUB, 6'h00, 1'b0, 1'b0, 52, 1'b0);
    rdc(OFF_ACC, 32'hFFFFFE);
    chk({31'h0, ovf}, 32'h0);
    wr(OFF_ACC, 32'h800000);
    wr(OFF_OPND, 32'h000001);
    run(OP_SUB, 6'h00, 1'b0, 1'b0, 52, 1'b0);
    rdc(OFF_ACC, 32'h7FFFFF);
    chk({31'h0, ovf}, 32'h1);
    $display("test sub done");
  endtask

  // Overflow left set by the subtract makes the first shift extend zeros
  task automatic t_mus;
    logic [31:0] r;
    logic e;
    multiply_step(32'hFFFFF8, 32'h7, 32'h5, 32'h3FFFFE, 32'h1);
    chk({31'h0, ovf}, 32'h0);
    multiply_step(32'hFFFFF8, 32'h7, 32'h5, 32'hFFFFFE, 32'h1);
    multiply_step(32'h0, 32'h4, 32'h1, 32'hFFFFFF, 32'h1);
    multiply_step(32'h0, 32'h1, 32'h2, 32'h000001, 32'h0);
    multiply_step(32'h0, 32'h3, 32'h1, 32'h000001, 32'h0);
    seq.xfer(1'b0, OFF_STAT, 32'h0, r, e);
    chk({30'h0, r[7:6]}, 32'h0);
    $display("test mus done");
  endtask

  task automatic t_shift;
    logic [31:0] r;
    logic e;
    wr(OFF_ACC, 32'h400001);
    wr(OFF_EXT, 32'h800001);
    run(OP_SHL, 6'h02, 1'b0, 1'b0, 130, 1'b0);
    rdc(OFF_ACC, 32'h000006);
    rdc(OFF_EXT, 32'h000004);
    chk({31'h0, ovf}, 32'h1);
    seq.xfer(1'b0, OFF_CTRL, 32'h0, r, e);
    chk({26'h0, r[13:8]}, {26'h0, OP_NOP});
    wr(OFF_STAT, 32'h10);
    wr(OFF_ACC, 32'h800000);
    wr(OFF_EXT, 32'h400000);
    run(OP_SHL, 6'h01, 1'b1, 1'b0, 104, 1'b0);
    rdc(OFF_ACC, 32'h000000);
    rdc(OFF_EXT, 32'h800001);
    chk({31'h0, ovf}, 32'h0);
    $display("test shift done");
  endtask

  // Fourteen shifts bring bit 8 under the sign, well before the count of 20
  task automatic t_norm;
    wr(OFF_ACC, 32'h000100);
    wr(OFF_EXT, 32'h000000);
    wr(OFF_IDX, 32'h00000A);
    run(OP_SHL, 6'h14, 1'b0, 1'b1, 442, 1'b0);
    rdc(OFF_ACC, 32'h400000);
    rdc(OFF_IDX, 32'hFFFFFC);
    $display("test norm done");
  endtask

  initial
  begin
    err_count = 0;
    n_checks = 0;
    resetn = 1'b0;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    t_reset;
    t_add;
    t_sub;
    t_mus;
    t_shift;
    t_norm;
    report_and_stop;
  end

  // All tests need about 1500 cycles
  initial
  begin
    repeat (30000) @(posedge mclk);
    err_count++;
    report_and_stop;
  end
endmodule
